/* verilog/scan_grader_params.svh */
`ifndef SCAN_GRADER_PARAMS_SVH
`define SCAN_GRADER_PARAMS_SVH

// Register byte offsets
`define REG_CTRL        8'h00
`define REG_REFERENCE   8'h04
`define REG_UPPER       8'h08
`define REG_LOWER       8'h0C
`define REG_STATUS      8'h10
`define REG_LAST_MEAS   8'h14
`define REG_TALLY       8'h18
`define REG_RESULT_BASE 8'h20

// Control field positions
`define CTRL_MODE_BIT   0
`define CTRL_TOGGLE_BIT 1
`define CTRL_FALL_BIT   2
`define CTRL_COUNT_LSB  8
`define CTRL_COUNT_MSB  14

// Status field positions
`define STAT_BUSY_BIT   0
`define STAT_GRADE_LSB  1
`define STAT_GRADE_MSB  2
`define STAT_CHAN_LSB   8
`define STAT_CHAN_MSB   14
`define STAT_SCANS_LSB  16
`define STAT_SCANS_MSB  31

// Reset values
`define RST_MODE        1'b0
`define RST_FALL        1'b0
`define RST_COUNT       7'h64
`define RST_REFERENCE   32'h0000_0000
`define RST_UPPER       32'h0000_0000
`define RST_LOWER       32'h0000_0000

// Scan limits and scaling
`define MAX_CHANNELS    7'h64
`define PCT_SCALE       66'sh0_0000_0000_0000_2710

`endif

/* verilog/scan_grader_pkg.sv */
`default_nettype none

package scan_grader_pkg;

   typedef enum logic [1:0] {
      GRADE_IN = 2'b00,
      GRADE_LO = 2'b01,
      GRADE_HI = 2'b10
   } grade_e;

   typedef enum logic [2:0] {
      C_IDLE  = 3'b000,
      C_MEAS  = 3'b001,
      C_WAIT  = 3'b010,
      C_GRADE = 3'b011,
      C_ACK   = 3'b100
   } core_state_e;

   typedef enum logic [2:0] {
      L_IDLE = 3'b000,
      L_CLK  = 3'b001,
      L_HOLD = 3'b010,
      L_SCAN_DONE_STROBE = 3'b011,
      L_END  = 3'b100
   } link_state_e;

   typedef struct packed {
      link_state_e state;
      logic        trig_s1;
      logic        trig_s2;
      logic        trig_s3;
      logic        fall_s1;
      logic        fall_s2;
      logic        req_s1;
      logic        req_s2;
      logic        req_s3;
      logic        busy;
      logic        last;
      logic        start_tgl;
      logic        ack_tgl;
      logic        hi;
      logic        lo;
      logic        pass;
      logic        relay;
      logic        gclk;
      logic        strobe;
   } link_s;

endpackage

`default_nettype wire

/* verilog/scan_compare_output.sv */
`timescale 1ns/1ps
`default_nettype none
`include "scan_grader_params.svh"

module scan_compare_output
   import scan_grader_pkg::*;
#(
   parameter int VALUE_W = 32
) (
   // Core clock and reset
   input  wire logic               clk,
   input  wire logic               rst_n,
   // Register port
   input  wire logic [7:0]         addr,
   input  wire logic [31:0]        wr_data,
   input  wire logic               wr_en,
   input  wire logic               rd_en,
   output logic      [31:0]        rd_data,
   // Measurement engine
   output logic                    meas_req,
   output logic      [6:0]         meas_channel,
   input  wire logic               meas_valid,
   input  wire logic [VALUE_W-1:0] meas_value,
   // Handler link
   input  wire logic               link_clk,
   input  wire logic               trigger,
   output logic                    high_out,
   output logic                    low_out,
   output logic                    pass_out,
   output logic                    relay_out,
   output logic                    group_clock,
   output logic                    scan_done_strobe
);

   typedef struct packed {
      core_state_e        state;
      logic               mode;
      logic               trig_fall;
      logic [6:0]         chan_count;
      logic [VALUE_W-1:0] reference;
      logic [VALUE_W-1:0] upper;
      logic [VALUE_W-1:0] lower;
      logic [VALUE_W-1:0] meas;
      logic [6:0]         channel;
      logic [1:0]         grade;
      logic               last;
      logic               busy;
      logic               start_pend;
      logic               req_tgl;
      logic               start_s1;
      logic               start_s2;
      logic               start_s3;
      logic               ack_s1;
      logic               ack_s2;
      logic               ack_s3;
      logic               meas_req;
      logic [6:0]         meas_channel;
      logic [15:0]        scans;
      logic [7:0]         n_in;
      logic [7:0]         n_lo;
      logic [7:0]         n_hi;
      logic               res_we;
      logic [31:0]        rd_data;
   } core_s;

   localparam core_s CORE_RESET = '{
      state:      C_IDLE,
      mode:       `RST_MODE,
      trig_fall:  `RST_FALL,
      chan_count: `RST_COUNT,
      reference:  VALUE_W'(`RST_REFERENCE),
      upper:      VALUE_W'(`RST_UPPER),
      lower:      VALUE_W'(`RST_LOWER),
      default:    '0
   };

   localparam link_s LINK_RESET = '{state: L_IDLE, default: '0};

   core_s c;
   core_s next_c;
   link_s l;
   link_s next_l;

   // Per-channel grades of the most recent scan
   logic [1:0] results [0:99];

   // Link-domain reset, synchronised from the core reset
   logic lrst_s1;
   logic lrst_s2;

   logic               start_evt;
   logic               ack_evt;
   logic [1:0]         graded;
   logic               trig_edge;
   logic               req_evt;
   logic [6:0]         res_idx;

   // Grading of the captured measurement
   always_comb begin
      logic signed [65:0] m;
      logic signed [65:0] r;
      logic signed [65:0] up;
      logic signed [65:0] lw;
      logic signed [65:0] dev;
      logic               below;
      logic               above;
      m   = $signed({{(66-VALUE_W){1'b0}}, c.meas});
      r   = $signed({{(66-VALUE_W){1'b0}}, c.reference});
      up  = $signed({{(66-VALUE_W){c.upper[VALUE_W-1]}}, c.upper});
      lw  = $signed({{(66-VALUE_W){c.lower[VALUE_W-1]}}, c.lower});
      dev = (m - r) * `PCT_SCALE;
      // Limits in hundredths of a percent; cross-multiplied to avoid a divider
      // A zero reference has no deviation to judge, so it grades IN
      below = c.mode ? (r != '0 && dev < lw * r) : (c.meas < c.lower);
      above = c.mode ? (r != '0 && dev > up * r) : (c.meas > c.upper);
      if (below) begin
         graded = GRADE_LO;
      end else if (above) begin
         graded = GRADE_HI;
      end else begin
         graded = GRADE_IN;
      end
   end

   assign start_evt = c.start_s2 ^ c.start_s3;
   assign ack_evt   = c.ack_s2 ^ c.ack_s3;
   assign res_idx   = addr[7:2] - 6'h08 + 7'h00;

   // Core domain
   always_comb begin
      logic [6:0] cnt;
      cnt = wr_data[`CTRL_COUNT_MSB:`CTRL_COUNT_LSB];
      next_c              = c;
      next_c.meas_req     = 1'b0;
      next_c.res_we       = 1'b0;
      next_c.rd_data      = 32'h0000_0000;
      next_c.start_s1     = l.start_tgl;
      next_c.start_s2     = c.start_s1;
      next_c.start_s3     = c.start_s2;
      next_c.ack_s1       = l.ack_tgl;
      next_c.ack_s2       = c.ack_s1;
      next_c.ack_s3       = c.ack_s2;

      if (wr_en) begin
         case (addr)
            `REG_CTRL: begin
               if (wr_data[`CTRL_TOGGLE_BIT]) begin
                  next_c.mode = ~c.mode;
               end
               next_c.trig_fall = wr_data[`CTRL_FALL_BIT];
               next_c.chan_count = (cnt == 7'h00) ? 7'h01 : ((cnt > `MAX_CHANNELS) ? `MAX_CHANNELS : cnt);
            end
            `REG_REFERENCE: next_c.reference = wr_data[VALUE_W-1:0];
            `REG_UPPER:     next_c.upper     = wr_data[VALUE_W-1:0];
            `REG_LOWER:     next_c.lower     = wr_data[VALUE_W-1:0];
            default: begin
            end
         endcase
      end

      if (rd_en) begin
         case (addr)
            `REG_CTRL: begin
               next_c.rd_data[`CTRL_MODE_BIT] = c.mode;
               next_c.rd_data[`CTRL_FALL_BIT] = c.trig_fall;
               next_c.rd_data[`CTRL_COUNT_MSB:`CTRL_COUNT_LSB] = c.chan_count;
            end
            `REG_REFERENCE: next_c.rd_data = 32'(c.reference);
            `REG_UPPER:     next_c.rd_data = 32'(c.upper);
            `REG_LOWER:     next_c.rd_data = 32'(c.lower);
            `REG_STATUS: begin
               next_c.rd_data[`STAT_BUSY_BIT] = c.busy;
               next_c.rd_data[`STAT_GRADE_MSB:`STAT_GRADE_LSB] = c.grade;
               next_c.rd_data[`STAT_CHAN_MSB:`STAT_CHAN_LSB] = c.channel;
               next_c.rd_data[`STAT_SCANS_MSB:`STAT_SCANS_LSB] = c.scans;
            end
            `REG_LAST_MEAS: next_c.rd_data = 32'(c.meas);
            `REG_TALLY:     next_c.rd_data = {8'h00, c.n_hi, c.n_lo, c.n_in};
            default: begin
               if (addr >= `REG_RESULT_BASE && res_idx < `MAX_CHANNELS) begin
                  next_c.rd_data = {30'h0000_0000, results[res_idx]};
               end
            end
         endcase
      end

      // A start that lands while a scan is closing is kept, not lost
      if (start_evt) begin
         next_c.start_pend = 1'b1;
      end

      case (c.state)
         C_IDLE: begin
            if (c.start_pend) begin
               next_c.start_pend = start_evt;
               next_c.busy       = 1'b1;
               next_c.channel    = 7'h00;
               next_c.n_in       = 8'h00;
               next_c.n_lo       = 8'h00;
               next_c.n_hi       = 8'h00;
               next_c.state      = C_MEAS;
            end
         end
         C_MEAS: begin
            next_c.meas_req     = 1'b1;
            next_c.meas_channel = c.channel;
            next_c.state        = C_WAIT;
         end
         C_WAIT: begin
            if (meas_valid) begin
               next_c.meas  = meas_value;
               next_c.state = C_GRADE;
            end
         end
         C_GRADE: begin
            // Grade and last stay put until the link acknowledges
            next_c.grade   = graded;
            next_c.last    = (c.channel == c.chan_count - 7'h01);
            next_c.req_tgl = ~c.req_tgl;
            next_c.res_we  = 1'b1;
            case (graded)
               GRADE_LO: next_c.n_lo = c.n_lo + 8'h01;
               GRADE_HI: next_c.n_hi = c.n_hi + 8'h01;
               default:  next_c.n_in = c.n_in + 8'h01;
            endcase
            next_c.state   = C_ACK;
         end
         C_ACK: begin
            if (ack_evt) begin
               if (c.last) begin
                  next_c.busy  = 1'b0;
                  next_c.scans = c.scans + 16'h0001;
                  next_c.state = C_IDLE;
               end else begin
                  next_c.channel = c.channel + 7'h01;
                  next_c.state   = C_MEAS;
               end
            end
         end
         default: begin
            next_c.state = C_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         c <= CORE_RESET;
      end else begin
         c <= next_c;
      end
   end

   always_ff @(posedge clk) begin
      if (c.res_we) begin
         results[c.channel] <= c.grade;
      end
   end

   // Reset synchroniser for the link domain
   always_ff @(posedge link_clk) begin
      lrst_s1 <= rst_n;
      lrst_s2 <= lrst_s1;
   end

   assign trig_edge = l.fall_s2 ? (~l.trig_s2 & l.trig_s3) : (l.trig_s2 & ~l.trig_s3);
   assign req_evt   = l.req_s2 ^ l.req_s3;

   // Link domain
   always_comb begin
      next_l         = l;
      next_l.trig_s1 = trigger;
      next_l.trig_s2 = l.trig_s1;
      next_l.trig_s3 = l.trig_s2;
      next_l.fall_s1 = c.trig_fall;
      next_l.fall_s2 = l.fall_s1;
      next_l.req_s1  = c.req_tgl;
      next_l.req_s2  = l.req_s1;
      next_l.req_s3  = l.req_s2;

      case (l.state)
         L_IDLE: begin
            if (trig_edge && !l.busy) begin
               next_l.busy      = 1'b1;
               next_l.start_tgl = ~l.start_tgl;
            end
            if (req_evt) begin
               // Core grade is stable here; the toggle handshake guards it
               next_l.hi    = (c.grade == GRADE_HI);
               next_l.lo    = (c.grade == GRADE_LO);
               next_l.pass  = (c.grade == GRADE_IN);
               next_l.relay = 1'b1;
               next_l.last  = c.last;
               next_l.state = L_CLK;
            end
         end
         L_CLK: begin
            // One cycle of setup before the rising edge
            next_l.gclk  = 1'b1;
            next_l.state = L_HOLD;
         end
         L_HOLD: begin
            next_l.gclk = 1'b0;
            if (l.last) begin
               next_l.state = L_SCAN_DONE_STROBE;
            end else begin
               next_l.ack_tgl = ~l.ack_tgl;
               next_l.state   = L_IDLE;
            end
         end
         L_SCAN_DONE_STROBE: begin
            next_l.strobe = 1'b1;
            next_l.state  = L_END;
         end
         L_END: begin
            next_l.strobe  = 1'b0;
            next_l.relay   = 1'b0;
            next_l.busy    = 1'b0;
            next_l.ack_tgl = ~l.ack_tgl;
            next_l.state   = L_IDLE;
         end
         default: begin
            next_l.state = L_IDLE;
         end
      endcase
   end

   always_ff @(posedge link_clk) begin
      if (!lrst_s2) begin
         l <= LINK_RESET;
      end else begin
         l <= next_l;
      end
   end

   assign rd_data          = c.rd_data;
   assign meas_req         = c.meas_req;
   assign meas_channel     = c.meas_channel;
   assign high_out         = l.hi;
   assign low_out          = l.lo;
   assign pass_out         = l.pass;
   assign relay_out        = l.relay;
   assign group_clock      = l.gclk;
   assign scan_done_strobe = l.strobe;

endmodule

`default_nettype wire

/* verification/scan_checker_sva.sv */
`timescale 1ns/1ps
`default_nettype none

module scan_checker (
   // Clocks and reset
   input wire logic       clk,
   input wire logic       link_clk,
   input wire logic       rst_n,
   // Measurement engine
   input wire logic       meas_req,
   input wire logic [6:0] meas_channel,
   // Handler link
   input wire logic       high_out,
   input wire logic       low_out,
   input wire logic       pass_out,
   input wire logic       relay_out,
   input wire logic       group_clock,
   input wire logic       scan_done_strobe
);
   logic [7:0] grp_cnt;

   // Groups since the last strobe
   always_ff @(posedge link_clk) begin
      if (!rst_n)
         grp_cnt <= 8'h00;
      else if (scan_done_strobe)
         grp_cnt <= 8'h00;
      else if (group_clock)
         grp_cnt <= grp_cnt + 8'h01;
   end

   sequence s_gc_pulse;
      group_clock ##1 !group_clock [*2];
   endsequence

   sequence s_held;
      $stable({high_out, low_out, pass_out, relay_out}) ##1 $stable({high_out, low_out, pass_out, relay_out});
   endsequence

   chk_gc_pulse: assert property (@(posedge link_clk) disable iff (!rst_n)
      group_clock |-> s_gc_pulse) else $error("group clock not a single pulse");
   chk_one_grade: assert property (@(posedge link_clk) disable iff (!rst_n)
      group_clock |-> $onehot({high_out, low_out, pass_out})) else $error("grade outputs not one-hot");
   chk_group_stable: assert property (@(posedge link_clk) disable iff (!rst_n)
      group_clock |-> s_held) else $error("group changed around clock pulse");
   chk_relay_group: assert property (@(posedge link_clk) disable iff (!rst_n)
      group_clock |-> relay_out) else $error("relay low during group");
   chk_strobe_order: assert property (@(posedge link_clk) disable iff (!rst_n)
      $rose(scan_done_strobe) |-> $past(group_clock, 2) && relay_out ##1 !scan_done_strobe)
      else $error("strobe out of order");
   chk_group_limit: assert property (@(posedge link_clk) disable iff (!rst_n)
      grp_cnt <= 8'h64) else $error("more than 100 groups in a scan");
   chk_done_after: assert property (@(posedge link_clk) disable iff (!rst_n)
      scan_done_strobe |-> grp_cnt != 8'h00) else $error("strobe without groups");
   chk_meas_pulse: assert property (@(posedge clk) disable iff (!rst_n)
      meas_req |-> meas_channel < 7'h64 ##1 !meas_req) else $error("bad measurement request");
endmodule

`default_nettype wire

/* verification/scan_handler.sv */
`timescale 1ns/1ps
`default_nettype none

module scan_handler (
   // Link clock and reset
   input  wire logic link_clk,
   input  wire logic rst_n,
   // Edge selection
   input  wire logic fall,
   // Result group from the device
   input  wire logic high_out,
   input  wire logic low_out,
   input  wire logic pass_out,
   input  wire logic relay_out,
   input  wire logic group_clock,
   input  wire logic scan_done_strobe,
   // Start request
   output logic      trigger
);
   logic       pulse;
   logic [3:0] grade_log [0:127];
   int         n_groups;
   int         n_done;

   initial begin
      pulse = 1'b0;
      n_groups = 0;
      n_done = 0;
   end

   // Idle level follows the chosen edge, so a start is one clean edge
   assign trigger = fall ^ pulse;

   // Held three link cycles so the two-flop sync cannot miss it
   task automatic fire();
      @(posedge link_clk);
      pulse <= 1'b1;
      repeat (3) @(posedge link_clk);
      pulse <= 1'b0;
   endtask

   task automatic clear();
      n_groups = 0;
   endtask

   always @(posedge link_clk) begin
      if (rst_n && group_clock) begin
         grade_log[n_groups[6:0]] <= {relay_out, high_out, low_out, pass_out};
         n_groups <= n_groups + 1;
      end
      if (rst_n && scan_done_strobe)
         n_done <= n_done + 1;
   end
endmodule

`default_nettype wire

/* verification/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, want) begin checks++; if ((got) !== (want)) begin n_errors++; \
   $display("CHECK FAILED at %0t: got %0h want %0h", $time, got, want); end end

module tb_top;
   logic        clk, link_clk, rst_n, wr_en, rd_en, meas_valid, fall_mode, eng_busy, pct;
   logic        meas_req, high_out, low_out, pass_out, relay_out, group_clock, scan_done_strobe;
   logic [7:0]  addr;
   logic [6:0]  meas_channel;
   logic [31:0] wr_data, rd_data, meas_value, seed, rdv;
   wire         trigger;
   int          n_errors, checks, exp_ch, wait_cnt, cycles, ref_v, up_v, lo_v;
   int          vals [0:99];
   logic [3:0]  exp_g;

   scan_compare_output uut (.clk(clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
      .rd_en(rd_en), .rd_data(rd_data), .meas_req(meas_req), .meas_channel(meas_channel),
      .meas_valid(meas_valid), .meas_value(meas_value), .link_clk(link_clk), .trigger(trigger),
      .high_out(high_out), .low_out(low_out), .pass_out(pass_out), .relay_out(relay_out),
      .group_clock(group_clock), .scan_done_strobe(scan_done_strobe));

   scan_handler h (.link_clk(link_clk), .rst_n(rst_n), .fall(fall_mode), .high_out(high_out),
      .low_out(low_out), .pass_out(pass_out), .relay_out(relay_out), .group_clock(group_clock),
      .scan_done_strobe(scan_done_strobe), .trigger(trigger));

   always #12.5 clk = ~clk;

   // Odd offset keeps the link clock out of phase with the core clock
   initial begin
      link_clk = 1'b0;
      #3.1;
      forever #7.5 link_clk = ~link_clk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic logic [3:0] exp_grade(input longint m);
      longint v, u, l;
      v = m;
      u = up_v;
      l = lo_v;
      if (pct) begin
         if (ref_v == 0)
            return 4'b1001;
         v = (m - ref_v) * 10000;
         u = longint'(up_v) * ref_v;
         l = longint'(lo_v) * ref_v;
      end
      if (v < l)
         return 4'b1010;
      if (v > u)
         return 4'b1100;
      return 4'b1001;
   endfunction

   function automatic logic [31:0] exp_tally(input int n);
      int t_in;
      int t_lo;
      int t_hi;
      t_in = 0;
      t_lo = 0;
      t_hi = 0;
      for (int i = 0; i < n; i++) begin
         case (exp_grade(vals[i]))
            4'b1010: t_lo++;
            4'b1100: t_hi++;
            default: t_in++;
         endcase
      end
      return {8'h00, t_hi[7:0], t_lo[7:0], t_in[7:0]};
   endfunction

   task automatic print_verdict();
      $display("errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      @(posedge clk);
      rdv = rd_data;
   endtask

   task automatic setup(input int r, input int u, input int l, input int base, input int span);
      ref_v = r;
      up_v = u;
      lo_v = l;
      wr(8'h04, 32'(r));
      wr(8'h08, 32'(u));
      wr(8'h0C, 32'(l));
      for (int i = 0; i < 100; i++) begin
         seed = lfsr(seed);
         vals[i] = base + int'(seed[15:0]) % span;
      end
   endtask

   task automatic run_scan(input int n, input bit extra);
      int d0;
      h.clear();
      exp_ch = 0;
      d0 = h.n_done;
      h.fire();
      if (extra) begin
         repeat (10) @(posedge link_clk);
         h.fire();
      end
      while (h.n_done == d0)
         @(posedge clk);
      repeat (300) @(posedge clk);
      `CHK(h.n_done, d0 + 1)
      `CHK(h.n_groups, n)
      for (int i = 0; i < n; i++)
         `CHK(h.grade_log[i], exp_grade(vals[i]))
   endtask

   // Measurement engine answering after a random delay
   always @(posedge clk) begin
      meas_valid <= 1'b0;
      if (meas_req) begin
         `CHK(meas_channel, exp_ch[6:0])
         exp_ch++;
         seed = lfsr(seed);
         wait_cnt = int'(seed[1:0]);
         eng_busy = 1'b1;
      end else if (eng_busy) begin
         if (wait_cnt == 0) begin
            meas_valid <= 1'b1;
            meas_value <= 32'(vals[meas_channel]);
            eng_busy = 1'b0;
         end else
            wait_cnt--;
      end
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         $display("CHECK FAILED at %0t: timeout", $time);
         print_verdict();
      end
   end

   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      addr = 8'h00;
      wr_data = 32'h0;
      wr_en = 1'b0;
      rd_en = 1'b0;
      meas_valid = 1'b0;
      meas_value = 32'h0;
      fall_mode = 1'b0;
      eng_busy = 1'b0;
      pct = 1'b0;
      seed = 32'h0FF6E636;
      n_errors = 0;
      checks = 0;
      cycles = 0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      rd(8'h00);
      `CHK(rdv, 32'h0000_6400)
      repeat (10) @(posedge clk);
      // Absolute limits, edges of the window, second start mid-scan
      setup(750, 1000, 500, 0, 2048);
      vals[0] = 499;
      vals[1] = 500;
      vals[2] = 1000;
      vals[3] = 1001;
      wr(8'h00, 32'h0000_0500);
      run_scan(5, 1'b1);
      // Percent deviation, limits of plus and minus 0.05 percent
      wr(8'h00, 32'h0000_0502);
      rd(8'h00);
      `CHK(rdv[0], 1'b1)
      pct = 1'b1;
      setup(10000, 5, -5, 9990, 21);
      vals[0] = 9994;
      vals[1] = 9995;
      vals[2] = 10005;
      vals[3] = 10006;
      run_scan(5, 1'b0);
      // Count of zero still runs one channel
      wr(8'h00, 32'h0000_0000);
      run_scan(1, 1'b0);
      // Back to absolute, falling start edge, full 100 channels
      wr(8'h00, 32'h0000_6406);
      rd(8'h00);
      `CHK(rdv[0], 1'b0)
      pct = 1'b0;
      fall_mode <= 1'b1;
      setup(750, 1000, 500, 0, 2048);
      run_scan(100, 1'b0);
      rd(8'h10);
      `CHK(rdv[31:16], 16'h0004)
      rd(8'h18);
      `CHK(rdv, exp_tally(100))
      exp_g = exp_grade(vals[5]);
      rd(8'h34);
      `CHK(rdv, {30'h0000_0000, exp_g[2:1]})
      rd(8'h1C);
      `CHK(rdv, 32'h0000_0000)
      print_verdict();
   end
endmodule

bind scan_compare_output scan_checker chk (.clk(clk), .link_clk(link_clk), .rst_n(rst_n),
   .meas_req(meas_req), .meas_channel(meas_channel), .high_out(high_out), .low_out(low_out),
   .pass_out(pass_out), .relay_out(relay_out), .group_clock(group_clock),
   .scan_done_strobe(scan_done_strobe));

`default_nettype wire
